/* design/msrc_consts.svh */
`ifndef MSRC_CONSTS_SVH
`define MSRC_CONSTS_SVH

// board command register offset and command codes
`define MSRC_BOARD_CMD_OFS 4'h0
`define MSRC_CMD_RUN 32'h0000000a
`define MSRC_CMD_RUN_BLK 32'h0000000b
`define MSRC_CMD_STD_LEADER 32'h00000064
`define MSRC_CMD_TRIG_LEADER 32'h00000065
`define MSRC_CMD_FIFO_LEADER 32'h00000066
`define MSRC_CMD_STD_FOLLOWER 32'h0000006e
`define MSRC_CMD_TRIG_FOLLOWER 32'h0000006f
`define MSRC_CMD_GROUP_ARM 32'h00000082
`define MSRC_CMD_RST 32'h00000000

// controller register offsets
`define MSRC_CTRL_OFS 8'h00
`define MSRC_FOLLOW_OFS 8'h04
`define MSRC_LEADER_OFS 8'h08
`define MSRC_HUB_OFS 8'h0c
`define MSRC_CLKLEAD_OFS 8'h10
`define MSRC_STATUS_OFS 8'h14
`define MSRC_IRQ_STAT_OFS 8'h18
`define MSRC_IRQ_MASK_OFS 8'h1c

// control register fields
`define MSRC_CTRL_GO 0
`define MSRC_CTRL_RERUN 1
`define MSRC_CTRL_BLOCK 2
`define MSRC_CTRL_FIFO 3
`define MSRC_CTRL_RST 4'h0

// interrupt status fields
`define MSRC_IRQ_DONE 0
`define MSRC_IRQ_ARMED 1
`define MSRC_IRQ_RST 2'h0

// timing
`define MSRC_CLK_NS 10
`define MSRC_RUN_NS 2000
`define MSRC_PRETRIG_NS 500
`define MSRC_RUN_CYC ((`MSRC_RUN_NS + `MSRC_CLK_NS - 1) / `MSRC_CLK_NS)
`define MSRC_PRETRIG_CYC ((`MSRC_PRETRIG_NS + `MSRC_CLK_NS - 1) / `MSRC_CLK_NS)

`endif

/* design/msrc_pkg.sv */
package msrc_pkg;
	typedef enum logic [1:0] {
		MSRC_CLK_NONE, MSRC_CLK_STD_LEADER, MSRC_CLK_FIFO_LEADER,
		MSRC_CLK_FOLLOWER
	} msrc_clk_role_t;
	typedef enum logic [1:0] {
		MSRC_TRIG_NONE, MSRC_TRIG_LEADER, MSRC_TRIG_FOLLOWER
	} msrc_trig_role_t;
	typedef enum {
		MSRC_B_IDLE, MSRC_B_ARMED, MSRC_B_WAIT_TRIG, MSRC_B_ACTIVE
	} msrc_board_st_t;
	typedef enum {
		MSRC_S_IDLE, MSRC_S_ROLE_TRIG, MSRC_S_ROLE_CLK, MSRC_S_ARM,
		MSRC_S_RUN_F, MSRC_S_RUN_L, MSRC_S_HUB_WAIT, MSRC_S_RUN_H,
		MSRC_S_SETTLE, MSRC_S_WAIT_RDY
	} msrc_seq_st_t;
endpackage

/* design/msrc_sync_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface msrc_sync_if #(parameter int N_BOARDS = 3);
	logic [N_BOARDS-1:0] cmd_stb;
	logic [3:0] cmd_addr;
	logic [31:0] cmd_code;
	wire [N_BOARDS-1:0] ready;
	wire [N_BOARDS-1:0] ack;
	wire [N_BOARDS-1:0] arm_req;
	wire [N_BOARDS-1:0] trig_req;

	modport ctrl (
		output cmd_stb, output cmd_addr, output cmd_code,
		input ready, input ack
	);
	modport board (
		input cmd_stb, input cmd_addr, input cmd_code,
		output ready, output ack, output arm_req, output trig_req
	);
endinterface
`default_nettype wire

/* design/msrc_run_timer.sv */
`timescale 1ns/10ps
`default_nettype none
`include "msrc_consts.svh"
module msrc_run_timer #(
	parameter int RUN_CYC = `MSRC_RUN_CYC
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic start,
	output logic done
);
	localparam int CW = $clog2(RUN_CYC + 1);
	localparam logic [CW-1:0] LAST = CW'(RUN_CYC - 1);
	logic [CW-1:0] cnt_reg, cnt_next;
	logic busy_reg, busy_next;
	logic done_reg, done_next;

	always_comb begin
		cnt_next = cnt_reg;
		busy_next = busy_reg;
		done_next = 1'b0;
		if (start) begin
			cnt_next = '0;
			busy_next = 1'b1;
		end else if (busy_reg) begin
			if (cnt_reg == LAST) begin
				busy_next = 1'b0;
				done_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + CW'(1);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			cnt_reg <= '0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
		end
	end

	assign done = done_reg;
endmodule
`default_nettype wire

/* design/msrc_board.sv */
`timescale 1ns/10ps
`default_nettype none
`include "msrc_consts.svh"
module msrc_board import msrc_pkg::*; #(
	parameter int N_BOARDS = 3,
	parameter int IDX = 0,
	parameter int RUN_CYC = `MSRC_RUN_CYC
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic trig_in,
	output logic armed,
	output logic running,
	output logic [31:0] board_command_register,
	msrc_sync_if.board bus
);
	msrc_board_st_t st_reg, st_next;
	msrc_clk_role_t clk_role_reg, clk_role_next;
	msrc_trig_role_t trig_role_reg, trig_role_next;
	logic [31:0] cmd_reg, cmd_next;
	logic blk_reg, blk_next;
	logic ready_reg, ready_next;
	logic ack_reg, ack_next;
	logic arm_reg, arm_next;
	logic trq_reg, trq_next;
	logic armed_reg, running_reg;
	logic trig_s1, trig_s2;
	logic group_arm, group_trig, run_start, run_done;

	// sync bus is a wired-or of every board's request
	assign group_arm = |bus.arm_req;
	assign group_trig = |bus.trig_req;
	assign run_start = (st_reg == MSRC_B_WAIT_TRIG) && group_trig;

	msrc_run_timer #(.RUN_CYC(RUN_CYC)) msrc_run_timer_inst (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.start(run_start),
		.done(run_done)
	);

	always_comb begin
		st_next = st_reg;
		clk_role_next = clk_role_reg;
		trig_role_next = trig_role_reg;
		cmd_next = cmd_reg;
		blk_next = blk_reg;
		ready_next = ready_reg;
		ack_next = 1'b0;
		arm_next = 1'b0;
		trq_next = 1'b0;
		if (bus.cmd_stb[IDX] && bus.cmd_addr == `MSRC_BOARD_CMD_OFS) begin
			cmd_next = bus.cmd_code;
			ack_next = 1'b1;
			case (bus.cmd_code)
			`MSRC_CMD_TRIG_LEADER: trig_role_next = MSRC_TRIG_LEADER;
			`MSRC_CMD_TRIG_FOLLOWER: trig_role_next = MSRC_TRIG_FOLLOWER;
			`MSRC_CMD_STD_LEADER: clk_role_next = MSRC_CLK_STD_LEADER;
			`MSRC_CMD_STD_FOLLOWER: clk_role_next = MSRC_CLK_FOLLOWER;
			`MSRC_CMD_FIFO_LEADER: clk_role_next = MSRC_CLK_FIFO_LEADER;
			`MSRC_CMD_GROUP_ARM: begin
				// only the clock leader may arm the group
				arm_next = (clk_role_reg == MSRC_CLK_STD_LEADER) ||
					(clk_role_reg == MSRC_CLK_FIFO_LEADER);
			end
			`MSRC_CMD_RUN, `MSRC_CMD_RUN_BLK: begin
				if (st_reg == MSRC_B_ARMED) begin
					st_next = MSRC_B_WAIT_TRIG;
					blk_next = (bus.cmd_code == `MSRC_CMD_RUN_BLK);
					ready_next = 1'b0;
					// blocking start answers only when the run is over
					ack_next = (bus.cmd_code == `MSRC_CMD_RUN);
				end
			end
			default: ;
			endcase
		end
		case (st_reg)
		MSRC_B_IDLE: begin
			if (group_arm) begin
				st_next = MSRC_B_ARMED;
			end
		end
		MSRC_B_ARMED: ;
		MSRC_B_WAIT_TRIG: begin
			// leaders are or-ed together onto the shared trigger line
			trq_next = (trig_role_reg == MSRC_TRIG_LEADER) && trig_s2;
			if (group_trig) begin
				st_next = MSRC_B_ACTIVE;
			end
		end
		MSRC_B_ACTIVE: begin
			if (run_done) begin
				st_next = MSRC_B_IDLE;
				ready_next = 1'b1;
				ack_next = blk_reg;
			end
		end
		default: st_next = MSRC_B_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			st_reg <= MSRC_B_IDLE;
			clk_role_reg <= MSRC_CLK_NONE;
			trig_role_reg <= MSRC_TRIG_NONE;
			cmd_reg <= `MSRC_CMD_RST;
			blk_reg <= 1'b0;
			ready_reg <= 1'b1;
			ack_reg <= 1'b0;
			arm_reg <= 1'b0;
			trq_reg <= 1'b0;
			armed_reg <= 1'b0;
			running_reg <= 1'b0;
			trig_s1 <= 1'b0;
			trig_s2 <= 1'b0;
		end else begin
			st_reg <= st_next;
			clk_role_reg <= clk_role_next;
			trig_role_reg <= trig_role_next;
			cmd_reg <= cmd_next;
			blk_reg <= blk_next;
			ready_reg <= ready_next;
			ack_reg <= ack_next;
			arm_reg <= arm_next;
			trq_reg <= trq_next;
			armed_reg <= (st_next == MSRC_B_ARMED);
			running_reg <= (st_next == MSRC_B_ACTIVE);
			trig_s1 <= trig_in;
			trig_s2 <= trig_s1;
		end
	end

	assign bus.ready[IDX] = ready_reg;
	assign bus.ack[IDX] = ack_reg;
	assign bus.arm_req[IDX] = arm_reg;
	assign bus.trig_req[IDX] = trq_reg;
	assign armed = armed_reg;
	assign running = running_reg;
	assign board_command_register = cmd_reg;
endmodule
`default_nettype wire

/* design/msrc_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
`include "msrc_consts.svh"
// Overview of operation
// - arm command on clock leader arms group
// - arm whole group before any start
// - code 10 starts, code 11 starts blocking
// - blocking start answers only after stop
// - start trigger followers first after arming
// - then start the trigger leaders
// - hub board leader is started last
// - other leaders fill pretrigger before hub
// - wait for every board ready afterwards
// - rerun repeats arm onward only
// - code 102 makes queue-mode clock leader
// - exactly one clock leader per group
// - fifo boards primed before their start
// - 101 trigger leader, 111 follower, or-ed
// - 100 clock leader, 110 clock follower
module msrc_ctrl import msrc_pkg::*; #(
	parameter int N_BOARDS = 3,
	parameter int PRETRIG_CYC = `MSRC_PRETRIG_CYC
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [7:0] sw_addr,
	input wire logic [31:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [31:0] sw_rdata,
	output logic irq,
	output logic seq_busy,
	input wire logic [N_BOARDS-1:0] buf_primed,
	msrc_sync_if.ctrl bus
);
	localparam int IW = (N_BOARDS > 1) ? $clog2(N_BOARDS) : 1;
	localparam int PW = $clog2(PRETRIG_CYC + 1);
	localparam logic [IW-1:0] LAST_IDX = IW'(N_BOARDS - 1);
	localparam logic [PW-1:0] PRE_LAST = PW'(PRETRIG_CYC - 1);

	logic [3:0] ctrl_reg, ctrl_next;
	logic [N_BOARDS-1:0] leader_reg, leader_next;
	logic [IW-1:0] hub_reg, hub_next;
	logic [IW-1:0] clklead_reg, clklead_next;
	logic [1:0] irq_stat_reg, irq_stat_next;
	logic [1:0] irq_mask_reg, irq_mask_next;
	logic [31:0] rdata_reg, rdata_next;
	logic irq_reg, busy_reg;
	logic go, rerun, fifo, blk;
	logic [1:0] ev;

	msrc_seq_st_t st_reg, st_next, succ;
	logic [IW-1:0] idx_reg, idx_next;
	logic wait_reg, wait_next;
	logic [PW-1:0] pre_reg, pre_next;
	logic [N_BOARDS-1:0] stb_reg, stb_next;
	logic [31:0] code_reg, code_next;
	logic sel, adv, is_run;
	logic [31:0] code;

	assign fifo = ctrl_reg[`MSRC_CTRL_FIFO];
	assign blk = ctrl_reg[`MSRC_CTRL_BLOCK];

	// software register port
	always_comb begin
		ctrl_next = ctrl_reg;
		leader_next = leader_reg;
		hub_next = hub_reg;
		clklead_next = clklead_reg;
		irq_mask_next = irq_mask_reg;
		irq_stat_next = irq_stat_reg;
		rdata_next = '0;
		go = 1'b0;
		rerun = 1'b0;
		if (sw_wr) begin
			case (sw_addr)
			`MSRC_CTRL_OFS: begin
				// start is refused while a sequence is in flight
				if (st_reg == MSRC_S_IDLE) begin
					ctrl_next = {sw_wdata[3:1], 1'b0};
					go = sw_wdata[`MSRC_CTRL_GO];
					rerun = sw_wdata[`MSRC_CTRL_RERUN];
				end
			end
			`MSRC_LEADER_OFS: leader_next = sw_wdata[N_BOARDS-1:0];
			`MSRC_HUB_OFS: hub_next = sw_wdata[IW-1:0];
			// one index field, so only one clock leader can be named
			`MSRC_CLKLEAD_OFS: clklead_next = sw_wdata[IW-1:0];
			`MSRC_IRQ_STAT_OFS: irq_stat_next = irq_stat_reg & ~sw_wdata[1:0];
			`MSRC_IRQ_MASK_OFS: irq_mask_next = sw_wdata[1:0];
			default: ;
			endcase
		end
		// a new event wins over a clear in the same cycle
		irq_stat_next = irq_stat_next | ev;
		if (sw_rd) begin
			case (sw_addr)
			`MSRC_CTRL_OFS: rdata_next = 32'(ctrl_reg);
			`MSRC_FOLLOW_OFS: rdata_next = {{(32-N_BOARDS){1'b0}}, ~leader_reg};
			`MSRC_LEADER_OFS: rdata_next = 32'(leader_reg);
			`MSRC_HUB_OFS: rdata_next = 32'(hub_reg);
			`MSRC_CLKLEAD_OFS: rdata_next = 32'(clklead_reg);
			`MSRC_STATUS_OFS: rdata_next = 32'({bus.ready, busy_reg});
			`MSRC_IRQ_STAT_OFS: rdata_next = 32'(irq_stat_reg);
			`MSRC_IRQ_MASK_OFS: rdata_next = 32'(irq_mask_reg);
			default: rdata_next = '0;
			endcase
		end
	end

	// sequencer: one board at a time, strictly in group order
	always_comb begin
		st_next = st_reg;
		idx_next = idx_reg;
		wait_next = wait_reg;
		pre_next = pre_reg;
		stb_next = '0;
		code_next = code_reg;
		ev = 2'b00;
		sel = 1'b0;
		adv = 1'b0;
		is_run = 1'b0;
		code = blk ? `MSRC_CMD_RUN_BLK : `MSRC_CMD_RUN;
		succ = MSRC_S_IDLE;
		case (st_reg)
		MSRC_S_IDLE: begin
			if (go) begin
				// rerun skips role setup and repeats arm onward
				st_next = rerun ? MSRC_S_ARM : MSRC_S_ROLE_TRIG;
				idx_next = '0;
				wait_next = 1'b0;
			end
		end
		MSRC_S_ROLE_TRIG: begin
			sel = 1'b1;
			code = leader_reg[idx_reg] ? `MSRC_CMD_TRIG_LEADER :
				`MSRC_CMD_TRIG_FOLLOWER;
			succ = MSRC_S_ROLE_CLK;
		end
		MSRC_S_ROLE_CLK: begin
			sel = 1'b1;
			if (idx_reg == clklead_reg) begin
				code = fifo ? `MSRC_CMD_FIFO_LEADER : `MSRC_CMD_STD_LEADER;
			end else begin
				code = `MSRC_CMD_STD_FOLLOWER;
			end
			succ = MSRC_S_ARM;
		end
		MSRC_S_ARM: begin
			sel = (idx_reg == clklead_reg);
			code = `MSRC_CMD_GROUP_ARM;
			succ = MSRC_S_RUN_F;
		end
		MSRC_S_RUN_F: begin
			is_run = 1'b1;
			sel = !leader_reg[idx_reg];
			succ = MSRC_S_RUN_L;
		end
		MSRC_S_RUN_L: begin
			is_run = 1'b1;
			sel = leader_reg[idx_reg] && (idx_reg != hub_reg);
			succ = MSRC_S_HUB_WAIT;
		end
		MSRC_S_HUB_WAIT: begin
			// give the other leaders time to fill their pretrigger
			if (pre_reg == PRE_LAST) begin
				pre_next = '0;
				st_next = MSRC_S_RUN_H;
			end else begin
				pre_next = pre_reg + PW'(1);
			end
		end
		MSRC_S_RUN_H: begin
			is_run = 1'b1;
			sel = leader_reg[idx_reg] && (idx_reg == hub_reg);
			succ = MSRC_S_SETTLE;
		end
		// lets the last board's ready drop before it is sampled
		MSRC_S_SETTLE: st_next = MSRC_S_WAIT_RDY;
		MSRC_S_WAIT_RDY: begin
			if (&bus.ready) begin
				st_next = MSRC_S_IDLE;
				ev[`MSRC_IRQ_DONE] = 1'b1;
			end
		end
		default: st_next = MSRC_S_IDLE;
		endcase
		if (succ != MSRC_S_IDLE) begin
			if (wait_reg) begin
				if (bus.ack[idx_reg]) begin
					wait_next = 1'b0;
					adv = 1'b1;
				end
			end else if (sel) begin
				// queue mode boards need primed buffers first
				if (!(is_run && fifo && !buf_primed[idx_reg])) begin
					stb_next[idx_reg] = 1'b1;
					code_next = code;
					// a blocking start is not waited for, like a thread
					wait_next = (code != `MSRC_CMD_RUN_BLK);
					adv = (code == `MSRC_CMD_RUN_BLK);
				end
			end else begin
				adv = 1'b1;
			end
		end
		if (adv) begin
			if (idx_reg == LAST_IDX) begin
				idx_next = '0;
				st_next = succ;
				ev[`MSRC_IRQ_ARMED] = (st_reg == MSRC_S_ARM);
			end else begin
				idx_next = idx_reg + IW'(1);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			ctrl_reg <= `MSRC_CTRL_RST;
			leader_reg <= '0;
			hub_reg <= '0;
			clklead_reg <= '0;
			irq_stat_reg <= `MSRC_IRQ_RST;
			irq_mask_reg <= `MSRC_IRQ_RST;
			rdata_reg <= '0;
			irq_reg <= 1'b0;
			busy_reg <= 1'b0;
			st_reg <= MSRC_S_IDLE;
			idx_reg <= '0;
			wait_reg <= 1'b0;
			pre_reg <= '0;
			stb_reg <= '0;
			code_reg <= `MSRC_CMD_RST;
		end else begin
			ctrl_reg <= ctrl_next;
			leader_reg <= leader_next;
			hub_reg <= hub_next;
			clklead_reg <= clklead_next;
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
			rdata_reg <= rdata_next;
			irq_reg <= |(irq_stat_next & irq_mask_next);
			busy_reg <= (st_next != MSRC_S_IDLE);
			st_reg <= st_next;
			idx_reg <= idx_next;
			wait_reg <= wait_next;
			pre_reg <= pre_next;
			stb_reg <= stb_next;
			code_reg <= code_next;
		end
	end

	assign bus.cmd_stb = stb_reg;
	assign bus.cmd_addr = `MSRC_BOARD_CMD_OFS;
	assign bus.cmd_code = code_reg;
	assign sw_rdata = rdata_reg;
	assign irq = irq_reg;
	assign seq_busy = busy_reg;
endmodule
`default_nettype wire

/* verification/msrc_sync_props.sv */
`timescale 1ns/10ps
`default_nettype none
`include "msrc_consts.svh"
module msrc_sync_props #(
	parameter int N_BOARDS = 3
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [N_BOARDS-1:0] cmd_stb,
	input wire logic [3:0] cmd_addr,
	input wire logic [31:0] cmd_code,
	input wire logic [N_BOARDS-1:0] ready,
	input wire logic [N_BOARDS-1:0] ack,
	input wire logic [N_BOARDS-1:0] arm_req,
	input wire logic [N_BOARDS-1:0] trig_req
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	sequence s_req;
		cmd_stb != '0;
	endsequence
	sequence s_run;
		s_req ##0 (cmd_code == `MSRC_CMD_RUN || cmd_code == `MSRC_CMD_RUN_BLK);
	endsequence
	property p_addr;
		s_req |-> cmd_addr == 4'h0;
	endproperty
	a_addr: assert property (p_addr) else $error("command offset not zero");
	property p_one;
		$onehot0(cmd_stb);
	endproperty
	a_one: assert property (p_one) else $error("two boards addressed");
	property p_ack_pulse;
		ack != '0 |=> (ack & $past(ack)) == '0;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_ack_ans;
		s_req ##0 cmd_code != `MSRC_CMD_RUN_BLK |=> ack == $past(cmd_stb);
	endproperty
	a_ack_ans: assert property (p_ack_ans) else $error("ack missing");
	property p_arm;
		s_req ##0 cmd_code == `MSRC_CMD_GROUP_ARM |-> ##[1:4] arm_req != '0;
	endproperty
	a_arm: assert property (p_arm) else $error("group not armed");
	property p_run;
		s_run |-> ##[1:2] ready != '1;
	endproperty
	a_run: assert property (p_run) else $error("run did not start");
	// a board may only leave ready in reply to its own command
	property p_fall;
		($past(ready) & ~ready & ~($past(cmd_stb) | $past(cmd_stb, 2))) == '0;
	endproperty
	a_fall: assert property (p_fall) else $error("board ran unasked");
	for (genvar i = 0; i < N_BOARDS; i++) begin : g_blk
		sequence s_blk;
			cmd_stb[i] && cmd_code == `MSRC_CMD_RUN_BLK;
		endsequence
		property p_blk;
			s_blk |=> (!ack[i]) [*4] ##[1:300] ack[i];
		endproperty
		a_blk: assert property (p_blk) else $error("blocking ack timing");
	end
endmodule
`default_nettype wire

/* verification/multi_board_sync_run_control_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "msrc_consts.svh"
module multi_board_sync_run_control_tb_top import msrc_pkg::*;;
	localparam int NB = 3;
	localparam int PRE = 2;
	logic core_clk, rst_b, sw_wr, sw_rd, irq, seq_busy, rd_d;
	logic [7:0] sw_addr;
	logic [31:0] sw_wdata, sw_rdata;
	logic [NB-1:0] buf_primed, trig_in, armed, running;
	logic [31:0] bcr [NB];
	logic [35:0] cmd_q[$];
	logic [35:0] rd_q[$];
	int failures, samples_checked, idx;
	int cyc = 0;
	int lead_cyc = 0;
	int hub_b;
	logic [NB-1:0] lead_m, prim_d;
	logic q_mode;
	msrc_sync_if #(.N_BOARDS(NB)) sync_if ();
	msrc_ctrl #(.N_BOARDS(NB), .PRETRIG_CYC(PRE)) msrc_ctrl_inst (
		.core_clk(core_clk), .rst_b(rst_b), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
		.sw_rdata(sw_rdata), .irq(irq), .seq_busy(seq_busy),
		.buf_primed(buf_primed), .bus(sync_if.ctrl));
	for (genvar i = 0; i < NB; i++) begin : g_brd
		msrc_board #(.N_BOARDS(NB), .IDX(i), .RUN_CYC(4)) msrc_board_inst (
			.core_clk(core_clk), .rst_b(rst_b), .trig_in(trig_in[i]),
			.armed(armed[i]), .running(running[i]),
			.board_command_register(bcr[i]), .bus(sync_if.board));
	end
	msrc_sync_props #(.N_BOARDS(NB)) msrc_sync_props_inst (
		.core_clk(core_clk), .rst_b(rst_b), .cmd_stb(sync_if.cmd_stb),
		.cmd_addr(sync_if.cmd_addr), .cmd_code(sync_if.cmd_code),
		.ready(sync_if.ready), .ack(sync_if.ack),
		.arm_req(sync_if.arm_req), .trig_req(sync_if.trig_req));
	task automatic check(input string what, input logic [35:0] seen,
			input logic [35:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge core_clk);
		sw_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		rd_q.push_back({4'h0, e});
		@(posedge core_clk);
		sw_rd <= 1'b0;
	endtask
	function automatic void cmd(input int b, input logic [31:0] c);
		cmd_q.push_back({b[3:0], c});
	endfunction
	task automatic wait_idle;
		int n;
		n = 0;
		repeat (3) @(posedge core_clk);
		while (seq_busy !== 1'b0) begin
			@(posedge core_clk);
			n++;
			if (n > 3000) begin
				check("seq_busy", seq_busy, 1'b0);
				give_verdict();
			end
		end
	endtask
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// random trigger and primed levels keep the waits data dependent
	always @(posedge core_clk) begin
		trig_in <= NB'($urandom);
		buf_primed <= NB'($urandom);
		// level the sequencer saw when it chose to launch a start
		prim_d <= buf_primed;
		cyc++;
		rd_d <= sw_rd;
		if (rd_d === 1'b1)
			check("sw_rdata", {4'h0, sw_rdata}, rd_q.pop_front());
		if (rst_b === 1'b1 && sync_if.cmd_stb !== '0) begin
			idx = 0;
			for (int i = 0; i < NB; i++)
				if (sync_if.cmd_stb[i]) idx = i;
			if (cmd_q.size() == 0)
				check("spare cmd", {idx[3:0], sync_if.cmd_code}, '1);
			else
				check("cmd", {idx[3:0], sync_if.cmd_code}, cmd_q.pop_front());
			if (sync_if.cmd_code == `MSRC_CMD_RUN ||
					sync_if.cmd_code == `MSRC_CMD_RUN_BLK) begin
				check("armed", {armed[idx], running[idx]}, 2'h2);
				if (q_mode)
					check("primed", prim_d[idx], 1'b1);
				if (lead_m[idx] && idx == hub_b) begin
					check("hub gap", cyc - lead_cyc >= PRE, 1'b1);
				end else if (lead_m[idx]) begin
					lead_cyc = cyc;
				end
			end
		end
	end
	initial begin
		void'($urandom(83361));
		{rst_b, sw_wr, sw_rd} = 3'h0;
		sw_addr = 8'h00;
		sw_wdata = 32'h0;
		lead_m = 3'h6;
		hub_b = 2;
		q_mode = 1'b0;
		failures = 0;
		samples_checked = 0;
		repeat (5) @(posedge core_clk);
		rst_b <= 1'b1;
		rd(`MSRC_STATUS_OFS, 32'he);
		rd(8'h20, 32'h0);
		wr(`MSRC_LEADER_OFS, 32'h6);
		wr(`MSRC_HUB_OFS, 32'h2);
		wr(`MSRC_CLKLEAD_OFS, 32'h0);
		wr(`MSRC_IRQ_MASK_OFS, 32'h3);
		rd(`MSRC_FOLLOW_OFS, 32'h1);
		cmd(0, `MSRC_CMD_TRIG_FOLLOWER);
		cmd(1, `MSRC_CMD_TRIG_LEADER);
		cmd(2, `MSRC_CMD_TRIG_LEADER);
		cmd(0, `MSRC_CMD_STD_LEADER);
		cmd(1, `MSRC_CMD_STD_FOLLOWER);
		cmd(2, `MSRC_CMD_STD_FOLLOWER);
		cmd(0, `MSRC_CMD_GROUP_ARM);
		cmd(0, `MSRC_CMD_RUN);
		cmd(1, `MSRC_CMD_RUN);
		cmd(2, `MSRC_CMD_RUN);
		wr(`MSRC_CTRL_OFS, 32'h1);
		// second go lands while busy and must leave no trace
		wr(`MSRC_CTRL_OFS, 32'h1);
		wait_idle();
		check("irq", irq, 1'b1);
		check("boards", {armed, running}, 6'h0);
		rd(`MSRC_IRQ_STAT_OFS, 32'h3);
		wr(`MSRC_IRQ_STAT_OFS, 32'h3);
		rd(`MSRC_IRQ_STAT_OFS, 32'h0);
		@(posedge core_clk);
		check("irq", irq, 1'b0);
		check("bcr", bcr[2], `MSRC_CMD_RUN);
		cmd(0, `MSRC_CMD_GROUP_ARM);
		for (int b = 0; b < NB; b++)
			cmd(b, `MSRC_CMD_RUN_BLK);
		wr(`MSRC_CTRL_OFS, 32'h7);
		wait_idle();
		lead_m = 3'h1;
		hub_b = 0;
		q_mode = 1'b1;
		wr(`MSRC_LEADER_OFS, 32'h1);
		wr(`MSRC_HUB_OFS, 32'h0);
		wr(`MSRC_CLKLEAD_OFS, 32'h1);
		cmd(0, `MSRC_CMD_TRIG_LEADER);
		cmd(1, `MSRC_CMD_TRIG_FOLLOWER);
		cmd(2, `MSRC_CMD_TRIG_FOLLOWER);
		cmd(0, `MSRC_CMD_STD_FOLLOWER);
		cmd(1, `MSRC_CMD_FIFO_LEADER);
		cmd(2, `MSRC_CMD_STD_FOLLOWER);
		cmd(1, `MSRC_CMD_GROUP_ARM);
		cmd(1, `MSRC_CMD_RUN);
		cmd(2, `MSRC_CMD_RUN);
		cmd(0, `MSRC_CMD_RUN);
		wr(`MSRC_CTRL_OFS, 32'h9);
		wait_idle();
		rd(`MSRC_STATUS_OFS, 32'he);
		repeat (3) @(posedge core_clk);
		check("cmd left", cmd_q.size(), 36'h0);
		give_verdict();
	end
endmodule
`default_nettype wire
